// ==== pkg/mse_pkg.sv ====
// Constants and types of the multidevice sync engine
`default_nettype none

package mse_pkg;

    // -----------------------------------------------------------------
    // Register map
    // -----------------------------------------------------------------
    localparam logic [7:0] MSE_ADDR_SYNC_CONTROL  = 8'h21;
    localparam logic [7:0] MSE_ADDR_FRAME_CONTROL = 8'h22;

    // Sync control fields
    localparam int MSE_SC_ENABLE_BIT    = 0;
    localparam int MSE_SC_EDGE_RISE_BIT = 1;

    // Frame control and status fields
    localparam int MSE_FC_MODE_LSB      = 0;
    localparam int MSE_FC_CONTINUOUS    = 2;
    localparam int MSE_FC_RECEIVED_BIT  = 3;

    // Reset values
    localparam logic [7:0] MSE_SYNC_CONTROL_RESET  = 8'h00;
    localparam logic [7:0] MSE_FRAME_CONTROL_RESET = 8'h00;

    // Synchroniser depth
    localparam int MSE_SYNC_STAGES = 2;

    // -----------------------------------------------------------------
    // Types
    // -----------------------------------------------------------------
    typedef enum logic [1:0] {
        MSE_MODE_FIFO     = 2'h0,
        MSE_MODE_FIFO_OSC = 2'h1,
        MSE_MODE_RESERVED = 2'h2,
        MSE_MODE_MONITOR  = 2'h3
    } mse_mode_t;

    typedef enum logic [1:0] {
        MSE_ST_IDLE  = 2'h0,
        MSE_ST_ARMED = 2'h1,
        MSE_ST_DONE  = 2'h3
    } mse_state_t;

    // Configuration handed from the register side to the link side
    typedef struct packed {
        logic [1:0] frameMode;
        logic       continuous;
        logic       edgeRise;
        logic       enable;
    } mse_cfg_t;

    // Reset requests toward FIFO and clock generation
    typedef struct packed {
        logic fifoReset;
        logic oscSync;
        logic clkGenAlign;
    } mse_resets_t;

endpackage : mse_pkg

`default_nettype wire

// ==== rtl/mse_sync_engine.sv ====
// Multidevice sync engine: registers, sync clock sampling, frame resets
`timescale 1ns/1ns
`default_nettype none

module mse_sync_engine
#(
    parameter int SYNC_STAGES = mse_pkg::MSE_SYNC_STAGES
)
(
    input  wire logic               core_clk,
    input  wire logic               rst,
    input  wire logic [7:0]         regAddr,
    input  wire logic [7:0]         regWrData,
    input  wire logic               regWrEn,
    input  wire logic               regRdEn,
    output logic [7:0]              regRdData,
    input  wire logic               pllEnabled,
    input  wire logic               pllLocked,
    input  wire logic               byteInterfaceMode,
    input  wire logic               conversion_clock,
    input  wire logic               convRst,
    input  wire logic               syncClockPin,
    input  wire logic               framePin,
    input  wire logic               data_clock_input,
    output mse_pkg::mse_resets_t    resetReq
);
    import mse_pkg::*;

    // Elaboration check on the synchroniser depth
    if (SYNC_STAGES < 2)
    begin : gen_bad_stages
        $error("SYNC_STAGES must be at least 2");
    end

    // -----------------------------------------------------------------
    // Register side (core_clk)
    // -----------------------------------------------------------------
    logic [7:0] syncControl;
    logic [2:0] frameControl;
    logic       receivedCore;
    logic       receivedMeta;
    logic       receivedSync;
    logic       receivedLink;
    mse_cfg_t   cfgCore;

    // Software writes to the two control registers
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            syncControl  <= MSE_SYNC_CONTROL_RESET;
            frameControl <= MSE_FRAME_CONTROL_RESET[2:0];
        end
        else if (regWrEn)
        begin
            if (regAddr == MSE_ADDR_SYNC_CONTROL)
                syncControl <= {6'h00, regWrData[MSE_SC_EDGE_RISE_BIT],
                                regWrData[MSE_SC_ENABLE_BIT]};
            if (regAddr == MSE_ADDR_FRAME_CONTROL)
                frameControl <= regWrData[MSE_FC_CONTINUOUS:MSE_FC_MODE_LSB];
        end
    end

    // Received flag from the link side, a level crossing three flops
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            receivedMeta <= 1'b0;
            receivedSync <= 1'b0;
            receivedCore <= 1'b0;
        end
        else
        begin
            receivedMeta <= receivedLink;
            receivedSync <= receivedMeta;
            receivedCore <= receivedSync;
        end
    end

    // Read data registered; unmapped offsets read as zero
    always_ff @(posedge core_clk)
    begin
        if (rst)
            regRdData <= 8'h00;
        else if (regRdEn)
        begin
            unique case (regAddr)
                MSE_ADDR_SYNC_CONTROL:  regRdData <= syncControl;
                MSE_ADDR_FRAME_CONTROL: regRdData <= {4'h0, receivedCore, frameControl};
                default:                regRdData <= 8'h00;
            endcase
        end
    end

    // Engine held off while an enabled PLL is not locked
    // registered so only flop outputs cross to the link clock
    always_ff @(posedge core_clk)
    begin
        if (rst)
            cfgCore <= '0;
        else
        begin
            cfgCore.frameMode  <= frameControl[1:0];
            cfgCore.continuous <= frameControl[MSE_FC_CONTINUOUS];
            cfgCore.edgeRise   <= syncControl[MSE_SC_EDGE_RISE_BIT];
            cfgCore.enable     <= syncControl[MSE_SC_ENABLE_BIT]
                                  && !(pllEnabled && !pllLocked);
        end
    end

    // -----------------------------------------------------------------
    // Link side (conversion_clock)
    // -----------------------------------------------------------------
    localparam int CFG_W = $bits(mse_cfg_t);

    logic [CFG_W-1:0] cfgPipe [SYNC_STAGES];
    mse_cfg_t         cfgLink;
    logic [SYNC_STAGES-1:0] byteModePipe;
    logic             byteModeLink;

    // Quasi-static configuration crosses as levels; software changes it
    // only while the engine is idle, so no word tearing is seen
    always_ff @(posedge conversion_clock)
    begin
        if (convRst)
        begin
            for (int i = 0; i < SYNC_STAGES; i++)
                cfgPipe[i] <= '0;
            byteModePipe <= '0;
        end
        else
        begin
            cfgPipe[0]   <= cfgCore;
            byteModePipe <= {byteModePipe[SYNC_STAGES-2:0], byteInterfaceMode};
            for (int i = 1; i < SYNC_STAGES; i++)
                cfgPipe[i] <= cfgPipe[i-1];
        end
    end
    assign cfgLink      = mse_cfg_t'(cfgPipe[SYNC_STAGES-1]);
    assign byteModeLink = byteModePipe[SYNC_STAGES-1];

    // Sync clock captured on both edges, one chosen later
    logic syncFallCap;
    logic syncRiseCap;
    logic syncFallSync;
    logic syncRiseSync;
    logic syncSel;
    logic syncSelDly;
    logic syncEdge;

    always_ff @(negedge conversion_clock)
    begin
        if (convRst)
            syncFallCap <= 1'b0;
        else
            syncFallCap <= syncClockPin;
    end

    // Rising edge capture and second stage of each capture path
    always_ff @(posedge conversion_clock)
    begin
        if (convRst)
        begin
            syncRiseCap  <= 1'b0;
            syncRiseSync <= 1'b0;
            syncFallSync <= 1'b0;
            syncSelDly   <= 1'b0;
        end
        else
        begin
            syncRiseCap  <= syncClockPin;
            syncRiseSync <= syncRiseCap;
            syncFallSync <= syncFallCap;
            syncSelDly   <= syncSel;
        end
    end

    // Falling edge capture unless rising is selected
    assign syncSel  = cfgLink.edgeRise ? syncRiseSync : syncFallSync;
    // Sampled low-to-high transition is the alignment point
    assign syncEdge = syncSel && !syncSelDly;

    // Frame and data clock input pins, two flops each, then edge logic
    logic [SYNC_STAGES-1:0] framePipe;
    logic [SYNC_STAGES-1:0] dciPipe;
    logic                   frameDly;
    logic                   dciDly;
    logic                   frameRise;
    logic                   dciRise;
    logic                   framePending;

    always_ff @(posedge conversion_clock)
    begin
        if (convRst)
        begin
            framePipe <= '0;
            dciPipe   <= '0;
            frameDly  <= 1'b0;
            dciDly    <= 1'b0;
        end
        else
        begin
            framePipe <= {framePipe[SYNC_STAGES-2:0], framePin};
            dciPipe   <= {dciPipe[SYNC_STAGES-2:0], data_clock_input};
            frameDly  <= framePipe[SYNC_STAGES-1];
            dciDly    <= dciPipe[SYNC_STAGES-1];
        end
    end

    assign frameRise = framePipe[SYNC_STAGES-1] && !frameDly;
    assign dciRise   = dciPipe[SYNC_STAGES-1] && !dciDly;

    // Engine state
    mse_state_t state;
    mse_state_t next_state;
    logic       frameAct;

    // Frames are not honoured in byte interface mode
    // Frame action waits for the next data clock input edge
    assign frameAct = (state == MSE_ST_ARMED) && framePending && dciRise;

    // Frame seen while armed is held until the data clock reference
    always_ff @(posedge conversion_clock)
    begin
        if (convRst || state != MSE_ST_ARMED)
            framePending <= 1'b0;
        else if (frameRise && !byteModeLink)
            framePending <= 1'b1;
        else if (frameAct)
            framePending <= 1'b0;
    end

    // Next state
    always_comb
    begin
        next_state = state;
        unique case (state)
            MSE_ST_IDLE:
                if (cfgLink.enable)
                    next_state = MSE_ST_ARMED;
            MSE_ST_ARMED:
                if (!cfgLink.enable)
                    next_state = MSE_ST_IDLE;
                // continuous mode stays armed for every frame, except in monitor mode
                // monitor mode stops after its first frame
                else if (frameAct && (!cfgLink.continuous
                                      || cfgLink.frameMode == MSE_MODE_MONITOR))
                    next_state = MSE_ST_DONE;
            MSE_ST_DONE:
                if (!cfgLink.enable)
                    next_state = MSE_ST_IDLE;
            default:
                next_state = MSE_ST_IDLE;
        endcase
    end

    always_ff @(posedge conversion_clock)
    begin
        if (convRst)
            state <= MSE_ST_IDLE;
        else
            state <= next_state;
    end

    // Received flag: set wins over the clear in the same cycle
    always_ff @(posedge conversion_clock)
    begin
        if (convRst)
            receivedLink <= 1'b0;
        // set on a taken frame pulse
        else if (frameAct)
            receivedLink <= 1'b1;
        // cleared while the engine is disabled
        else if (!cfgLink.enable)
            receivedLink <= 1'b0;
    end

    // Reset requests, one conversion_clock cycle each, from flops
    always_ff @(posedge conversion_clock)
    begin
        if (convRst)
            resetReq <= '0;
        else
        begin
            resetReq.fifoReset <= frameAct;
            resetReq.oscSync   <= frameAct
                                  && (cfgLink.frameMode == MSE_MODE_FIFO_OSC
                                      || cfgLink.frameMode == MSE_MODE_MONITOR);
            // realign clock generation on sync edges while armed
            resetReq.clkGenAlign <= syncEdge && (state == MSE_ST_ARMED);
        end
    end

endmodule : mse_sync_engine

`default_nettype wire

// ==== verification/mse_far_side.sv ====
// Far-side model: shared sync clock, data clock input and frame pin
`timescale 1ns/1ns
`default_nettype none

module mse_far_side
(
    input  wire logic conversion_clock,
    output logic      syncClockPin,
    output logic      data_clock_input,
    output logic      framePin
);
    logic [3:0] phase = 4'h0;

    // Free-running divider; all clocks derive from it so edges stay related
    always @(posedge conversion_clock)
        phase <= phase + 4'h1;

    // pins move on rising edges, clear of falling sampling
    // one sync clock at data rate over 8
    assign data_clock_input = phase[0];
    assign syncClockPin     = phase[3];

    initial framePin = 1'b0;

    // frame wider than one data clock, spaced by caller
    task automatic send_frame;
        @(posedge conversion_clock);
        framePin <= 1'b1;
        repeat (8) @(posedge conversion_clock);
        framePin <= 1'b0;
    endtask : send_frame
endmodule : mse_far_side

`default_nettype wire

// ==== verification/mse_sync_engine_properties.sv ====
// Concurrent checks on the sync engine ports
`timescale 1ns/1ns
`default_nettype none

module mse_sync_engine_properties
(
    input wire logic                 core_clk,
    input wire logic                 rst,
    input wire logic [7:0]           regAddr,
    input wire logic [7:0]           regWrData,
    input wire logic                 regWrEn,
    input wire logic                 regRdEn,
    input wire logic [7:0]           regRdData,
    input wire logic                 conversion_clock,
    input wire logic                 convRst,
    input wire logic                 framePin,
    input wire logic                 byteInterfaceMode,
    input wire mse_pkg::mse_resets_t resetReq
);
    import mse_pkg::*;
    logic [4:0] frameAge;

    // Cycles since the frame pin was last high; saturates so it cannot wrap
    always_ff @(posedge conversion_clock)
    begin
        if (convRst)
            frameAge <= 5'h1F;
        else if (framePin)
            frameAge <= 5'h00;
        else if (frameAge != 5'h1F)
            frameAge <= frameAge + 5'h01;
    end

    chk_fifo_one_cycle:
    assert property (@(posedge conversion_clock) disable iff (convRst)
        resetReq.fifoReset |=> !resetReq.fifoReset) else $error("fifo reset too long");
    chk_fifo_after_frame:
    assert property (@(posedge conversion_clock) disable iff (convRst)
        resetReq.fifoReset |-> frameAge < 5'h10) else $error("fifo reset without frame");
    chk_osc_one_cycle:
    assert property (@(posedge conversion_clock) disable iff (convRst)
        resetReq.oscSync |=> !resetReq.oscSync) else $error("osc sync too long");
    chk_osc_with_fifo:
    assert property (@(posedge conversion_clock) disable iff (convRst)
        resetReq.oscSync |-> resetReq.fifoReset) else $error("osc sync alone");
    chk_byte_no_reset:
    assert property (@(posedge conversion_clock) disable iff (convRst)
        byteInterfaceMode [*8] |-> !resetReq.fifoReset) else $error("frame in byte mode");
    chk_unmapped_zero:
    assert property (@(posedge core_clk) disable iff (rst)
        regRdEn && regAddr != 8'h21 && regAddr != 8'h22 |=> regRdData == 8'h00)
        else $error("unmapped read not zero");
    chk_ctl_readback:
    assert property (@(posedge core_clk) disable iff (rst)
        regWrEn && regAddr == 8'h21 ##1 !regWrEn ##1 regRdEn && !regWrEn && regAddr == 8'h21
        |=> regRdData == ($past(regWrData, 3) & 8'h03)) else $error("control readback");
    chk_mode_readback:
    assert property (@(posedge core_clk) disable iff (rst)
        regWrEn && regAddr == 8'h22 ##1 !regWrEn ##1 regRdEn && !regWrEn && regAddr == 8'h22
        |=> (regRdData & 8'h07) == ($past(regWrData, 3) & 8'h07)) else $error("mode readback");
    chk_read_holds:
    assert property (@(posedge core_clk) disable iff (rst)
        !regRdEn |=> $stable(regRdData)) else $error("read data moved");

    cov_osc_reset: cover property (@(posedge conversion_clock) resetReq.oscSync);
    cov_align: cover property (@(posedge conversion_clock) resetReq.clkGenAlign);
    cov_received: cover property (@(posedge core_clk) regRdData[3]);
endmodule : mse_sync_engine_properties

bind mse_sync_engine mse_sync_engine_properties mse_sync_engine_properties_inst
(
    .core_clk(core_clk),
    .rst(rst),
    .regAddr(regAddr),
    .regWrData(regWrData),
    .regWrEn(regWrEn),
    .regRdEn(regRdEn),
    .regRdData(regRdData),
    .conversion_clock(conversion_clock),
    .convRst(convRst),
    .framePin(framePin),
    .byteInterfaceMode(byteInterfaceMode),
    .resetReq(resetReq)
);

`default_nettype wire

// ==== verification/tb.sv ====
// Self-checking bench for the multidevice sync engine
`timescale 1ns/1ns
`default_nettype none

module tb;
    import mse_pkg::*;
    logic        core_clk, rst, regWrEn, regRdEn, pllEnabled, pllLocked, byteInterfaceMode;
    logic        conversion_clock, convRst, syncClockPin, framePin, data_clock_input;
    logic [7:0]  regAddr, regWrData, regRdData;
    mse_resets_t resetReq;
    int          fails = 0, tests_run = 0, cycles = 0, fifoCnt = 0, oscCnt = 0, alignCnt = 0;

    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    // Link clock starts after a 7 ns offset; its edges still meet a core clock edge every 60 ns
    initial
    begin
        conversion_clock = 1'b0;
        #7;
        forever #3 conversion_clock = ~conversion_clock;
    end

    mse_sync_engine mse_sync_engine_inst (.core_clk(core_clk), .rst(rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
        .pllEnabled(pllEnabled), .pllLocked(pllLocked), .byteInterfaceMode(byteInterfaceMode),
        .conversion_clock(conversion_clock), .convRst(convRst), .syncClockPin(syncClockPin),
        .framePin(framePin), .data_clock_input(data_clock_input), .resetReq(resetReq));
    mse_far_side mse_far_side_inst (.conversion_clock(conversion_clock),
        .syncClockPin(syncClockPin), .data_clock_input(data_clock_input), .framePin(framePin));

    // Free-running pulse tallies; scenarios look only at differences
    always @(posedge conversion_clock)
    begin
        fifoCnt += resetReq.fifoReset;
        oscCnt += resetReq.oscSync;
        alignCnt += resetReq.clkGenAlign;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
            fails++;
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        @(negedge core_clk);
        regWrEn = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge core_clk);
        regAddr = a;
        regRdEn = 1'b1;
        @(negedge core_clk);
        regRdEn = 1'b0;
        @(negedge core_clk);
        check(regRdData, exp);
    endtask : rd

    // Two frames; the pause lets the enable cross and the flag come back
    task automatic frame_pair(output logic [7:0] f, output logic [7:0] o);
        int f0, o0;
        repeat (2) @(negedge core_clk);
        f0 = fifoCnt;
        o0 = oscCnt;
        repeat (2)
        begin
            mse_far_side_inst.send_frame();
            repeat (8) @(negedge core_clk);
        end
        f = 8'(fifoCnt - f0);
        o = 8'(oscCnt - o0);
    endtask : frame_pair

    task automatic tally_and_finish;
        $display("checks %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish

    // Hang guard; a normal run needs well under a thousand cycles
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            fails++;
            tally_and_finish();
        end
    end

    initial
    begin
        logic [7:0] f, o;
        int a0;
        {rst, convRst} = 2'h3;
        {regWrEn, regRdEn, pllEnabled, pllLocked, byteInterfaceMode} = 5'h00;
        regAddr = 8'h00;
        regWrData = 8'h00;
        repeat (20) @(negedge core_clk);
        rst = 1'b0;
        convRst = 1'b0;
        rd(MSE_ADDR_SYNC_CONTROL, MSE_SYNC_CONTROL_RESET);
        rd(MSE_ADDR_FRAME_CONTROL, MSE_FRAME_CONTROL_RESET);
        rd(8'h30, 8'h00);
        wr(MSE_ADDR_FRAME_CONTROL, 8'h0F);
        rd(MSE_ADDR_FRAME_CONTROL, 8'h07);
        frame_pair(f, o);
        check(f, 8'h00);
        // Every frame mode in one-shot, sampling edge alternating
        for (int m = 0; m < 4; m++)
        begin
            wr(MSE_ADDR_FRAME_CONTROL, 8'(m));
            a0 = alignCnt;
            wr(MSE_ADDR_SYNC_CONTROL, {6'h00, m[0], 1'b1});
            rd(MSE_ADDR_SYNC_CONTROL, {6'h00, m[0], 1'b1});
            repeat (10) @(negedge core_clk);
            check(8'(alignCnt > a0), 8'h01);
            frame_pair(f, o);
            check(f, 8'h01);
            check(o, 8'(m % 2));
            rd(MSE_ADDR_FRAME_CONTROL, 8'(m) | 8'h08);
            wr(MSE_ADDR_SYNC_CONTROL, 8'h00);
            repeat (4) @(negedge core_clk);
            rd(MSE_ADDR_FRAME_CONTROL, 8'(m));
        end
        wr(MSE_ADDR_FRAME_CONTROL, 8'h04);
        wr(MSE_ADDR_SYNC_CONTROL, 8'h01);
        frame_pair(f, o);
        check(f, 8'h02);
        wr(MSE_ADDR_SYNC_CONTROL, 8'h00);
        byteInterfaceMode = 1'b1;
        wr(MSE_ADDR_SYNC_CONTROL, 8'h01);
        frame_pair(f, o);
        check(f, 8'h00);
        rd(MSE_ADDR_FRAME_CONTROL, 8'h04);
        wr(MSE_ADDR_SYNC_CONTROL, 8'h00);
        byteInterfaceMode = 1'b0;
        wr(MSE_ADDR_FRAME_CONTROL, 8'h07);
        wr(MSE_ADDR_SYNC_CONTROL, 8'h01);
        frame_pair(f, o);
        check(f, 8'h01);
        check(o, 8'h01);
        wr(MSE_ADDR_SYNC_CONTROL, 8'h00);
        wr(MSE_ADDR_FRAME_CONTROL, 8'h00);
        pllEnabled = 1'b1;
        wr(MSE_ADDR_SYNC_CONTROL, 8'h01);
        frame_pair(f, o);
        check(f, 8'h00);
        pllLocked = 1'b1;
        frame_pair(f, o);
        check(f, 8'h01);
        tally_and_finish();
    end
endmodule : tb

`default_nettype wire
